// ### hdl/oslp_unit.sv
// Purpose: One-shot contacts, latch/unlatch, word bit ops and pause.
// Assumes: Program steps arrive one per cycle, scan boundary on i_scan.
// Notes: Physical inputs go through a three-stage synchroniser.
module oslp_unit
    import oslp_pkg::*;
#(
    parameter int NPTS = OSLP_NPTS
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_scan,
    input wire logic [NPTS-1:0] i_phys_in,
    input wire logic [NPTS-1:0] i_in_installed,
    input wire logic [NPTS-1:0] i_out_point,
    input wire logic [4:0] i_op,
    input wire logic [OSLP_AW-1:0] i_first,
    input wire logic [OSLP_AW-1:0] i_last,
    input wire logic i_rung,
    input wire logic [OSLP_AW-1:0] i_ref,
    input wire logic [OSLP_WAW-1:0] i_waddr,
    input wire logic [4:0] i_wbit,
    input wire logic i_pause_rung,
    input wire logic [OSLP_AW-1:0] i_pause_first,
    input wire logic [OSLP_AW-1:0] i_pause_last,
    input wire logic [NPTS-1:0] i_pause_override,
    output logic o_rise_rung,
    output logic o_fall_rung,
    output logic [NPTS-1:0] o_image,
    output logic [NPTS-1:0] o_phys_out,
    output logic [OSLP_WW-1:0] o_word,
    output logic o_bad_bit
);
    if (NPTS != OSLP_NPTS) begin : g_chk
        $error("NPTS must equal the package point count");
    end

    // Synchroniser stages for physical inputs.
    logic [NPTS-1:0] sy1_q, sy2_q, sy3_q;
    // Debounced physical input level.
    logic [NPTS-1:0] in_q;
    // Image register and its previous-scan copy.
    logic [NPTS-1:0] img_q, img_d, prev_q;
    // Pause mask, combinational, applied at the scan boundary.
    logic [NPTS-1:0] pmask;

    ////////////////////////////////////////////////////////////////////////
    // Three-flop synchroniser; change counts once stages 2 and 3 agree.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sy1_q <= '0;
            sy2_q <= '0;
            sy3_q <= '0;
            in_q <= '0;
        end else if (i_ce) begin
            sy1_q <= i_phys_in;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            in_q <= (sy2_q & sy3_q) | (in_q & (sy2_q | sy3_q));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode of the step; the step in this cycle is the latest in order.
    wire logic op_lat = i_rung && (i_op == OSLP_OP_LATCH);
    wire logic op_unl = i_rung && (i_op == OSLP_OP_UNLAT);
    wire logic op_wset = i_rung && (i_op == OSLP_OP_WBSET);
    wire logic op_wclr = i_rung && (i_op == OSLP_OP_WBCLR);
    // Bit index arrives in BCD; only 0 to 15 is legal.
    wire logic [4:0] wbit_bin = 5'(i_wbit[4] ? 5'h0A + {1'b0, i_wbit[3:0]}
                                             : {1'b0, i_wbit[3:0]});
    wire logic wbit_ok = (i_wbit[3:0] <= 4'h9) && (wbit_bin <= OSLP_BIT_MAX);

    // Range masks per point, built in one loop.
    logic [NPTS-1:0] rng, in_pause;
    for (genvar p = 0; p < NPTS; p++) begin : g_pt
        assign rng[p] = (OSLP_AW'(p) >= i_first) && (OSLP_AW'(p) <= i_last);
        assign in_pause[p] = (OSLP_AW'(p) >= i_pause_first) &&
                             (OSLP_AW'(p) <= i_pause_last);
    end

    // Next image: installed inputs always follow the pins.
    always_comb begin
        img_d = img_q;
        if (op_lat) begin
            img_d = img_q | rng;
        end else if (op_unl) begin
            img_d = img_q & ~rng;
        end
        // Installed inputs cannot be held by a latch.
        img_d = (img_d & ~i_in_installed) | (in_q & i_in_installed);
    end
    // The program keeps timer and counter points off latch operands.

    // Points paused unless overridden.
    assign pmask = {NPTS{i_pause_rung}} & in_pause & ~i_pause_override;

    ////////////////////////////////////////////////////////////////////////
    // Image, previous-scan copy and physical outputs.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            img_q <= '0;
            prev_q <= '0;
            o_phys_out <= '0;
        end else if (i_ce) begin
            img_q <= img_d;
            if (i_scan) begin
                prev_q <= img_q;
                o_phys_out <= img_q & i_out_point & ~pmask;
            end
        end
    end

    // Edge of the referenced point against last scan.
    wire logic cur_ref = img_q[i_ref];
    wire logic old_ref = prev_q[i_ref];
    wire logic rise_c = cur_ref && !old_ref;
    wire logic fall_c = !cur_ref && old_ref;

    // Registered rung results and image view.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rise_rung <= 1'b0;
            o_fall_rung <= 1'b0;
            o_image <= '0;
            o_bad_bit <= 1'b0;
        end else if (i_ce) begin
            o_rise_rung <= i_rung && rise_c;
            o_fall_rung <= i_rung && fall_c;
            o_image <= img_q;
            o_bad_bit <= (op_wset || op_wclr) && !wbit_ok;
        end
    end

    // Word memory, bit operations only with a legal index.
    oslp_word_mem u_mem (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_addr(i_waddr),
        .i_bit(wbit_bin[3:0]),
        .i_set(op_wset && wbit_ok),
        .i_clr(op_wclr && wbit_ok),
        .o_rdata(o_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks. Helper copies of the previous cycle come first, because the
    // properties below read them. They carry no reset: every check is
    // disabled while reset is high, so their reset value never matters.
    logic [NPTS-1:0] rng_past, inst_past, img_past, in_past, pm_past;
    // Output point mask of the previous cycle, for the override check.
    logic [NPTS-1:0] opt_past;
    // Helper copies follow every edge, even a frozen one, on purpose.
    always_ff @(posedge i_clk) begin
        rng_past <= rng;
        inst_past <= i_in_installed;
        img_past <= img_q;
        in_past <= in_q;
        pm_past <= pmask;
        opt_past <= i_out_point;
    end

    // A rising contact under a true rung, taken on a running cycle.
    sequence s_rise;
        i_rung && rise_c && i_ce;
    endsequence
    // A legal word bit set, taken on a running cycle.
    sequence s_wset;
        i_ce && op_wset && wbit_ok;
    endsequence
    // A legal word bit clear, taken on a running cycle.
    sequence s_wclr;
        i_ce && op_wclr && wbit_ok;
    endsequence
    // The same word is read again, so the registered read shows the write.
    sequence s_same_word;
        i_ce && (i_waddr == $past(i_waddr));
    endsequence

    // One-shot contacts and their series combination with the rung.
    AST_RISE: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        s_rise |=> o_rise_rung)
        else $error("rise contact missed");
    AST_FALL: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_rung && fall_c) |=> o_fall_rung)
        else $error("fall contact missed");
    AST_AND: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !i_rung) |=> !o_rise_rung && !o_fall_rung)
        else $error("one-shot passed false rung");
    AST_PREV: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_scan) |=> (prev_q == img_past))
        else $error("previous-scan copy not taken");

    // Latch, unlatch and the points that no instruction may hold.
    AST_LAT: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && op_lat) |=>
        ((img_q & rng_past & ~inst_past) == (rng_past & ~inst_past)))
        else $error("latch range not set");
    AST_UNL: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && op_unl) |=> ((img_q & rng_past & ~inst_past) == '0))
        else $error("unlatch range not cleared");
    AST_HOLD: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !op_lat && !op_unl) |=>
        ((img_q & ~inst_past) == (img_past & ~inst_past)))
        else $error("image changed without instruction");
    AST_INST: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce) |=> ((img_q & inst_past) == (in_past & inst_past)))
        else $error("installed input held by latch");

    // Word bit operations; the read lags the write by one cycle.
    AST_WSET: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        s_wset ##1 s_same_word |=> o_word[$past(wbit_bin[3:0], 2)])
        else $error("word bit not set");
    AST_WCLR: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        s_wclr ##1 s_same_word |=> !o_word[$past(wbit_bin[3:0], 2)])
        else $error("word bit not cleared");
    AST_BAD: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && (op_wset || op_wclr) && !wbit_ok) |=> o_bad_bit)
        else $error("illegal bit index not flagged");

    // Pause: paused points are off, all other output points follow the image.
    AST_PAUSE: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_scan) |=> ((o_phys_out & pm_past) == '0))
        else $error("paused output driven");
    AST_OVR: assert property (
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_scan) |=>
        (((o_phys_out ^ (img_past & opt_past)) & ~pm_past) == '0))
        else $error("unpaused output not updated");
endmodule // oslp_unit

// ### hdl/oslp_word_mem.sv
// Purpose: Word memory with read-modify-write of a single bit.
// Assumes: Bit index is already validated as binary 0 to 15.
// Notes: Read data comes from a register, one cycle after the address.
module oslp_word_mem
    import oslp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [OSLP_WAW-1:0] i_addr,
    input wire logic [3:0] i_bit,
    input wire logic i_set,
    input wire logic i_clr,
    output logic [OSLP_WW-1:0] o_rdata
);
    // Storage; reset clears all words so state is defined.
    logic [OSLP_WW-1:0] mem_q [OSLP_NWORDS];
    // Mask of the one selected bit.
    wire logic [OSLP_WW-1:0] bit_mask = OSLP_WW'(1) << i_bit;

    ////////////////////////////////////////////////////////////////////////
    // Each word updates only its selected bit, others untouched.
    for (genvar w = 0; w < OSLP_NWORDS; w++) begin : g_word
        wire logic hit = (i_addr == OSLP_WAW'(w));
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                mem_q[w] <= OSLP_WORD_RST;
            end else if (i_ce && hit && i_set) begin
                mem_q[w] <= mem_q[w] | bit_mask;
            end else if (i_ce && hit && i_clr) begin
                mem_q[w] <= mem_q[w] & ~bit_mask;
            end
        end
    end

    // Registered read port.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= OSLP_WORD_RST;
        end else if (i_ce) begin
            o_rdata <= mem_q[i_addr];
        end
    end
endmodule // oslp_word_mem

// ### pkg/oslp_pkg.sv
// Purpose: Shared constants and types for the one-shot, latch and pause unit.
// Assumes: One controller scan is marked by a one-cycle scan strobe.
// Notes: Image points and word memory are small arrays held in the unit.
package oslp_pkg;
    // Number of image points and word memory depth.
    localparam int OSLP_NPTS = 32;
    localparam int OSLP_AW = 5;
    localparam int OSLP_NWORDS = 16;
    localparam int OSLP_WAW = 4;
    localparam int OSLP_WW = 16;
    // Highest legal bit index of a word, as a binary value.
    localparam logic [4:0] OSLP_BIT_MAX = 5'h0F;
    // Reset value of words and of the word read register.
    localparam logic [OSLP_WW-1:0] OSLP_WORD_RST = 16'h0000;
    // Instruction codes, one-hot, executed one per cycle in program order.
    typedef enum logic [4:0] {
        OSLP_OP_NONE   = 5'h01,
        OSLP_OP_LATCH  = 5'h02,
        OSLP_OP_UNLAT  = 5'h04,
        OSLP_OP_WBSET  = 5'h08,
        OSLP_OP_WBCLR  = 5'h10
    } oslp_op_t;
endpackage

// ### test/oslp_io_model.sv
// Purpose: Pin-side model of the physical input modules.
// Assumes: Only installed inputs carry a real level.
// Notes: Empty slots float, so they toggle every cycle.
module oslp_io_model #(
    parameter logic [31:0] INST = 32'h0010_0000
) (
    input wire logic i_clk,
    input wire logic [31:0] i_level,
    output logic [31:0] o_pins,
    output logic [31:0] o_inst
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flip_q = 1'b0; // Floating-pin pattern.
    // A floating pin must never look like stable data.
    always @(posedge i_clk) begin
        flip_q <= ~flip_q;
    end
    assign o_pins = (i_level & INST) | ({32{flip_q}} & ~INST);
    assign o_inst = INST; // Slot map of installed input modules.
endmodule // oslp_io_model

// ### test/test_oslp_unit.sv
// Purpose: Self-checking bench for the one-shot, latch and pause unit.
// Assumes: Rung and refusal flags answer one cycle after a step is taken, image and word two.
// Notes: Row table first, then pause, edges, order and reset cases.
module test_oslp_unit
    import oslp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] op, first, last;
        logic rung;
        logic [4:0] wbit;
        logic [31:0] img;
        logic [15:0] word;
    } oslp_row_t;
    // Word 3 is used throughout; image and word values are cumulative.
    // Latch rows name plain image points only, no timer or counter.
    oslp_row_t rows [10] = '{
        '{OSLP_OP_LATCH, 5'h02, 5'h05, 1'b1, 5'h00, 32'h3C, 16'h0},
        '{OSLP_OP_LATCH, 5'h00, 5'h1F, 1'b0, 5'h00, 32'h3C, 16'h0},
        '{OSLP_OP_UNLAT, 5'h03, 5'h03, 1'b1, 5'h00, 32'h34, 16'h0},
        '{OSLP_OP_UNLAT, 5'h02, 5'h05, 1'b0, 5'h00, 32'h34, 16'h0},
        '{OSLP_OP_LATCH, 5'h1F, 5'h1F, 1'b1, 5'h00, 32'h8000_0034, 16'h0},
        '{OSLP_OP_WBSET, 5'h00, 5'h00, 1'b1, 5'h15, 32'h8000_0034, 16'h8000},
        '{OSLP_OP_WBSET, 5'h00, 5'h00, 1'b1, 5'h00, 32'h8000_0034, 16'h8001},
        '{OSLP_OP_WBSET, 5'h00, 5'h00, 1'b0, 5'h09, 32'h8000_0034, 16'h8001},
        '{OSLP_OP_WBCLR, 5'h00, 5'h00, 1'b1, 5'h15, 32'h8000_0034, 16'h0001},
        '{OSLP_OP_WBSET, 5'h00, 5'h00, 1'b1, 5'h10, 32'h8000_0034, 16'h0401}};
    logic clk = 1'b0, rst = 1'b1, scan = 1'b0, rung = 1'b0, prung = 1'b0;
    logic bad_seen = 1'b0, rise, fall, bad;
    logic ce = 1'b1; // Clock enable, dropped once to prove the freeze.
    logic [4:0] op = OSLP_OP_NONE, nxt = OSLP_OP_NONE;
    logic [4:0] first = 5'h00, last = 5'h00, ref_pt = 5'h00, wbit = 5'h00;
    logic [3:0] waddr = 4'h3;
    logic [31:0] level = 32'h0, ovr = 32'h0, pins, inst, image, phys;
    logic [15:0] word;
    int bad_count = 0;
    int n_tests = 0;
    oslp_io_model oslp_io_model_i (.i_clk(clk), .i_level(level),
        .o_pins(pins), .o_inst(inst));
    oslp_unit oslp_unit_i (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
        .i_scan(scan), .i_phys_in(pins), .i_in_installed(inst),
        .i_out_point(32'h0000_FFFF), .i_op(op), .i_first(first),
        .i_last(last), .i_rung(rung), .i_ref(ref_pt), .i_waddr(waddr),
        .i_wbit(wbit), .i_pause_rung(prung), .i_pause_first(5'h02),
        .i_pause_last(5'h04), .i_pause_override(ovr), .o_rise_rung(rise),
        .o_fall_rung(fall), .o_image(image), .o_phys_out(phys),
        .o_word(word), .o_bad_bit(bad));
    always #5 clk = ~clk;
    // The refusal flag is a pulse, so it is caught here.
    always @(posedge clk) if (bad === 1'b1) bad_seen <= 1'b1;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One step, then the queued step, then idle until outputs settle.
    task automatic step(input logic [4:0] o, f, l, input logic r,
        input logic [4:0] b);
        @(posedge clk);
        op <= o;
        first <= f;
        last <= l;
        rung <= r;
        wbit <= b;
        ref_pt <= b;
        @(posedge clk);
        op <= nxt;
        @(posedge clk);
        op <= OSLP_OP_NONE;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // End of scan; the pause inputs are sampled with it.
    task automatic do_scan(input logic p, input logic [31:0] ov);
        @(posedge clk);
        prung <= p;
        ovr <= ov;
        scan <= 1'b1;
        @(posedge clk);
        scan <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        chk("image", 32'h0, image);
        chk("phys", 32'h0, phys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            step(rows[i].op, rows[i].first, rows[i].last, rows[i].rung,
                rows[i].wbit);
            chk("image", rows[i].img, image);
            chk("word", rows[i].word, word);
        end
        do_scan(1'b0, 32'h0);
        chk("phys", 32'h34, phys);
        do_scan(1'b1, 32'h10);
        chk("phys", 32'h30, phys);
        chk("image", 32'h8000_0034, image);
        do_scan(1'b1, 32'h0);
        chk("phys", 32'h20, phys);
        do_scan(1'b0, 32'h0);
        step(OSLP_OP_LATCH, 5'h07, 5'h07, 1'b1, 5'h07);
        chk("rise", 32'h1, rise);
        step(OSLP_OP_NONE, 5'h00, 5'h00, 1'b0, 5'h07);
        chk("rise", 32'h0, rise);
        do_scan(1'b0, 32'h0);
        step(OSLP_OP_UNLAT, 5'h07, 5'h07, 1'b1, 5'h07);
        chk("rise", 32'h0, rise);
        chk("fall", 32'h1, fall);
        do_scan(1'b0, 32'h0);
        step(OSLP_OP_NONE, 5'h00, 5'h00, 1'b1, 5'h07);
        chk("fall", 32'h0, fall);
        nxt = OSLP_OP_UNLAT;
        step(OSLP_OP_LATCH, 5'h09, 5'h09, 1'b1, 5'h00);
        chk("image", 32'h8000_0034, image);
        nxt = OSLP_OP_LATCH;
        step(OSLP_OP_UNLAT, 5'h09, 5'h09, 1'b1, 5'h00);
        chk("image", 32'h8000_0234, image);
        nxt = OSLP_OP_NONE;
        bad_seen = 1'b0;
        step(OSLP_OP_WBSET, 5'h00, 5'h00, 1'b1, 5'h0A);
        chk("bad", 32'h1, bad_seen);
        chk("word", 32'h0401, word);
        step(OSLP_OP_LATCH, 5'h14, 5'h14, 1'b1, 5'h00);
        chk("image", 32'h8000_0234, image);
        @(posedge clk);
        level <= 32'h0010_0000;
        repeat (8) @(posedge clk);
        step(OSLP_OP_UNLAT, 5'h14, 5'h14, 1'b1, 5'h00);
        chk("image", 32'h8010_0234, image);
        // A latch taken while the clock enable is low must leave no trace.
        @(posedge clk);
        ce <= 1'b0;
        step(OSLP_OP_LATCH, 5'h0B, 5'h0B, 1'b1, 5'h00);
        chk("image", 32'h8010_0234, image);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("image", 32'h8010_0234, image);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk("image", 32'h0, image);
        chk("word", 32'h0, word);
        chk("phys", 32'h0, phys);
        stop_test();
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        #50000;
        bad_count++;
        stop_test();
    end
endmodule // test_oslp_unit
